// File: dv/spf_framer_props.sv
// assertions on the status packet framer ports
`timescale 1ns/1ns
`default_nettype none
module spf_framer_props (
  input wire logic I_CLK, // clock
  input wire logic I_NRST, // reset, low
  input wire logic I_SYS_ON, // on-state
  input wire logic I_TEC_SD, // cooler shutdown
  input wire logic I_INTERLOCK, // interlock
  input wire logic I_TX_READY, // sink ready
  input wire logic [7:0] O_TX_DATA, // packet byte
  input wire logic O_TX_VALID, // byte valid
  input wire logic O_TOUT_ERR // timeout flag
);
  // ==========================
  // byte position tracker
  logic [4:0] pos;
  wire logic take = O_TX_VALID && I_TX_READY;
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST)
      pos <= 5'h00;
    else if (take)
      pos <= (pos == 5'h19) ? 5'h00 : pos + 5'h01;
  end
  // ==========================
  // properties
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);
  a_start_pair: assert property (O_TX_VALID && pos < 5'h02 |-> O_TX_DATA == 8'h0a)
    else $error("start byte wrong");
  a_stop_pair: assert property (O_TX_VALID && pos > 5'h17 |-> O_TX_DATA == 8'h0b)
    else $error("stop byte wrong");
  a_stop_end: assert property (take && pos == 5'h19 |=> !O_TX_VALID)
    else $error("packet runs past last byte");
  a_no_gap: assert property (take && pos < 5'h19 |=> O_TX_VALID)
    else $error("gap inside packet");
  a_byte_hold: assert property (O_TX_VALID && !I_TX_READY |=> O_TX_VALID && $stable(O_TX_DATA))
    else $error("byte changed before taken");
  a_on_flag: assert property (O_TX_VALID && pos == 5'h02 |-> O_TX_DATA[2] == I_SYS_ON)
    else $error("on-state flag wrong");
  a_tsd_flag: assert property (O_TX_VALID && pos == 5'h03 |-> O_TX_DATA[4] == I_TEC_SD)
    else $error("shutdown flag wrong");
  a_lio_unused: assert property (O_TX_VALID && pos == 5'h17 |-> O_TX_DATA[7:1] == 7'h00)
    else $error("unused io bits set");
  a_err_cause: assert property ($rose(O_TOUT_ERR) |-> $past(I_INTERLOCK))
    else $error("timeout error without interlock");
endmodule
bind spf_framer spf_framer_props u_props (.I_CLK(I_CLK), .I_NRST(I_NRST), .I_SYS_ON(I_SYS_ON),
  .I_TEC_SD(I_TEC_SD), .I_INTERLOCK(I_INTERLOCK), .I_TX_READY(I_TX_READY),
  .O_TX_DATA(O_TX_DATA), .O_TX_VALID(O_TX_VALID), .O_TOUT_ERR(O_TOUT_ERR));
`default_nettype wire

// File: dv/spf_framer_tb_top.sv
// testbench for the status packet framer
`timescale 1ns/1ns
`default_nettype none
module spf_framer_tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic sys_on = 1'b0;
  logic tec_sd = 1'b0;
  logic lock = 1'b0;
  logic slow = 1'b0;
  wire logic [31:0] hrdata;
  wire logic hready;
  wire logic hresp;
  wire logic [7:0] tx_data;
  wire logic tx_valid;
  wire logic tx_ready;
  wire logic dec_fault;
  wire logic tout_err;
  wire logic irq;
  int failures = 0;
  int n_tests = 0;
  logic [7:0] srcs [0:5] = '{8'h00, 8'h25, 8'h4a, 8'h90, 8'h03, 8'hc0};
  always #20 clk = ~clk;
  spf_framer #(.TICK(10)) DUT (.I_CLK(clk), .I_NRST(nrst), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'b010), .I_HWDATA(hwdata),
    .I_HREADY(hready), .I_SYS_ON(sys_on), .I_TEC_SD(tec_sd), .I_INTERLOCK(lock),
    .I_TX_READY(tx_ready), .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp),
    .O_TX_DATA(tx_data), .O_TX_VALID(tx_valid), .O_DEC_FAULT(dec_fault),
    .O_TOUT_ERR(tout_err), .O_IRQ(irq));
  spf_sink u_sink (.clk(clk), .rst_n(nrst), .i_slow(slow), .i_valid(tx_valid),
    .i_data(tx_data), .o_ready(tx_ready));
  // ==========================
  // tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wrap_up;
    if (failures == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(nm, e, r);
    chk("hresp", 32'h0, hresp);
  endtask
  // ==========================
  // watchdog
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    wrap_up();
  end
  // ==========================
  // main sequence
  initial begin
    logic [7:0] st;
    int n0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rdc("unmapped", 8'h20, 32'h0);
    rdc("mask_reset", spf_pkg::REG_IRQ_MASK, 32'h0);
    for (int i = 0; i < 6; i++) begin
      sys_on <= i[0];
      tec_sd <= i[1];
      slow <= i[0];
      wr(spf_pkg::REG_SRC, {24'h0, srcs[i]});
      wr(spf_pkg::REG_LSRC, {24'h0, srcs[i]});
      wr(spf_pkg::REG_STATE, {16'h0, 7'h7f, i[0], 8'h5b});
      rdc("state_rd", spf_pkg::REG_STATE, {16'h0, 7'h7f, i[0], 8'h5b});
      wr(spf_pkg::REG_TOUT, {16'h0, srcs[i], ~srcs[i]});
      repeat (2) @(posedge clk);
      chk("dec_fault", {31'h0, i > 3}, {31'h0, dec_fault});
      n0 = u_sink.n_pkts;
      wr(spf_pkg::REG_CTRL, 32'h1);
      for (int k = 0; k < 400 && u_sink.n_pkts == n0; k++) @(posedge clk);
      chk("pkt_count", n0 + 1, u_sink.n_pkts);
      st = 8'h5b;
      st[spf_pkg::BIT_ON] = i[0];
      chk("start", {2{spf_pkg::START_BYTE}}, {u_sink.pkt[0], u_sink.pkt[1]});
      chk("state", st, u_sink.pkt[2]);
      chk("tsd", i[1], u_sink.pkt[3][spf_pkg::BIT_TSD]);
      chk("src", srcs[i], u_sink.pkt[4]);
      chk("tout", {srcs[i], ~srcs[i]}, {u_sink.pkt[20], u_sink.pkt[21]});
      chk("lsrc", srcs[i], u_sink.pkt[22]);
      chk("lio", {7'h0, i[0]}, u_sink.pkt[23]);
      chk("stop", {2{spf_pkg::STOP_BYTE}}, {u_sink.pkt[24], u_sink.pkt[25]});
      rdc("irq_stat", spf_pkg::REG_IRQ_STAT, {29'h0, 2'b10, i == 4});
      if (i == 4) begin
        chk("irq_masked", 32'h0, irq);
        wr(spf_pkg::REG_IRQ_MASK, 32'h3);
        repeat (2) @(posedge clk);
        chk("irq_raised", 32'h1, irq);
      end
      wr(spf_pkg::REG_IRQ_STAT, 32'h7);
      repeat (2) @(posedge clk);
      chk("irq_cleared", 32'h0, irq);
    end
    wr(spf_pkg::REG_TOUT, 32'h3);
    lock <= 1'b1;
    repeat (30) @(posedge clk);
    chk("tout_early", 32'h0, tout_err);
    repeat (20) @(posedge clk);
    chk("tout_err", 32'h1, tout_err);
    chk("tout_irq", 32'h1, irq);
    rdc("status", spf_pkg::REG_STATUS, 32'h6);
    lock <= 1'b0;
    repeat (5) @(posedge clk);
    chk("tout_clear", 32'h0, tout_err);
    wrap_up();
  end
endmodule
`default_nettype wire

// File: dv/spf_sink.sv
// serial host model collecting packet bytes
`timescale 1ns/1ns
`default_nettype none
module spf_sink (
  input wire logic clk, // clock
  input wire logic rst_n, // reset, low
  input wire logic i_slow, // stall every other cycle
  input wire logic i_valid, // byte valid
  input wire logic [7:0] i_data, // packet byte
  output logic o_ready // byte taken
);
  logic [7:0] pkt [0:25];
  int cnt;
  int n_pkts;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      o_ready <= 1'b0;
      cnt <= 0;
      n_pkts <= 0;
    end else begin
      o_ready <= i_slow ? !o_ready : 1'b1;
      if (i_valid && o_ready) begin
        pkt[cnt] <= i_data;
        cnt <= (cnt == 25) ? 0 : cnt + 1;
        if (cnt == 25)
          n_pkts <= n_pkts + 1;
      end
    end
  end
endmodule
`default_nettype wire

// File: rtl/spf_framer.sv
// status packet framer with ahb-lite register slave
//
// Local design decisions: the AHB-Lite register port and the register addresses.

`timescale 1ns/1ns
`default_nettype none
module spf_framer #(
  parameter int TICK = spf_pkg::TICK_CYCLES
) (
  input wire logic I_CLK, // system clock
  input wire logic I_NRST, // async reset, low
  input wire logic I_HSEL, // ahb select
  input wire logic [31:0] I_HADDR, // ahb address
  input wire logic [1:0] I_HTRANS, // ahb transfer type
  input wire logic I_HWRITE, // ahb write
  input wire logic [2:0] I_HSIZE, // ahb size
  input wire logic [31:0] I_HWDATA, // ahb write data
  input wire logic I_HREADY, // ahb bus ready
  input wire logic I_SYS_ON, // system on-state
  input wire logic I_TEC_SD, // cooler shutdown active
  input wire logic I_INTERLOCK, // temperature interlock active
  input wire logic I_TX_READY, // serial sink takes byte
  output logic [31:0] O_HRDATA, // ahb read data
  output logic O_HREADYOUT, // ahb ready
  output logic O_HRESP, // ahb response
  output logic [7:0] O_TX_DATA, // packet byte
  output logic O_TX_VALID, // packet byte valid
  output logic O_DEC_FAULT, // decoder fault flag
  output logic O_TOUT_ERR, // timeout error flag
  output logic O_IRQ // interrupt level
);
  // ==========================================
  // reset release
  logic rst_a, rst_n;
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      rst_a <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_a <= 1'b1;
      rst_n <= rst_a;
    end
  end

  // ==========================================
  // bus slave and registers
  spf_pkg::spf_fields_t mem, next_mem;
  logic [2:0] irq_stat, next_irq_stat, irq_mask, next_irq_mask, ev;
  logic dp_wr, next_dp_wr, dp_rd, next_dp_rd, go, next_go;
  logic [7:0] dp_addr, next_dp_addr;
  logic [31:0] rdata, next_rdata;
  logic busy, dec_fault, tout_err;

  always_comb begin
    next_dp_wr = 1'b0;
    next_dp_rd = 1'b0;
    next_dp_addr = dp_addr;
    next_mem = mem;
    next_irq_mask = irq_mask;
    next_go = 1'b0;
    next_irq_stat = irq_stat;
    next_rdata = rdata;
    if (I_HSEL && I_HREADY && I_HTRANS[1]) begin
      next_dp_wr = I_HWRITE;
      next_dp_rd = !I_HWRITE;
      next_dp_addr = I_HADDR[7:0];
    end
    if (dp_wr) begin
      case (dp_addr)
        spf_pkg::REG_CTRL: next_go = I_HWDATA[0];
        spf_pkg::REG_STATE: begin
          next_mem.op_state = I_HWDATA[7:0];
          next_mem.lio = I_HWDATA[15:8];
        end
        spf_pkg::REG_SRC: next_mem.src = I_HWDATA[7:0];
        spf_pkg::REG_LSRC: next_mem.lsrc = I_HWDATA[7:0];
        spf_pkg::REG_TOUT: next_mem.tout = I_HWDATA[15:0];
        spf_pkg::REG_IRQ_STAT: next_irq_stat = irq_stat & ~I_HWDATA[2:0];
        spf_pkg::REG_IRQ_MASK: next_irq_mask = I_HWDATA[2:0];
        default: ;
      endcase
    end
    // set wins over clear
    next_irq_stat = next_irq_stat | ev;
    if (I_HSEL && I_HREADY && I_HTRANS[1] && !I_HWRITE) begin
      case (I_HADDR[7:0])
        spf_pkg::REG_STATE: next_rdata = {16'h0, mem.lio, mem.op_state};
        spf_pkg::REG_SRC: next_rdata = {24'h0, mem.src};
        spf_pkg::REG_LSRC: next_rdata = {24'h0, mem.lsrc};
        spf_pkg::REG_TOUT: next_rdata = {16'h0, mem.tout};
        spf_pkg::REG_IRQ_STAT: next_rdata = {29'h0, irq_stat};
        spf_pkg::REG_IRQ_MASK: next_rdata = {29'h0, irq_mask};
        spf_pkg::REG_STATUS: next_rdata = {29'h0, tout_err, dec_fault, busy};
        default: next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      dp_wr <= 1'b0;
      dp_rd <= 1'b0;
      dp_addr <= 8'h00;
      mem <= '0;
      irq_stat <= 3'h0;
      irq_mask <= 3'h0;
      go <= 1'b0;
      rdata <= 32'h0;
    end else begin
      dp_wr <= next_dp_wr;
      dp_rd <= next_dp_rd;
      dp_addr <= next_dp_addr;
      mem <= next_mem;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      go <= next_go;
      rdata <= next_rdata;
    end
  end

  // ==========================================
  // decoder check
  function automatic logic src_bad(input logic [7:0] b);
    logic bad;
    bad = 1'b0;
    if (b[1:0] == 2'b11) bad = 1'b1;
    if (b[4:2] != 3'b000 && b[4:2] != 3'b001 && b[4:2] != 3'b010 && b[4:2] != 3'b100)
      bad = 1'b1;
    if (b[7:5] != 3'b000 && b[7:5] != 3'b001 && b[7:5] != 3'b010 && b[7:5] != 3'b100)
      bad = 1'b1;
    return bad;
  endfunction

  // ==========================================
  // timeout supervision
  logic [31:0] tick_cnt, next_tick_cnt;
  logic [15:0] steps, next_steps;
  logic next_dec_fault, next_tout_err;

  always_comb begin
    next_tick_cnt = tick_cnt;
    next_steps = steps;
    next_tout_err = tout_err;
    next_dec_fault = src_bad(mem.src) || src_bad(mem.lsrc);
    if (!I_INTERLOCK) begin
      next_tick_cnt = 32'h0;
      next_steps = 16'h0;
      next_tout_err = 1'b0;
    end else if (!tout_err) begin
      if (tick_cnt == 32'(TICK - 1)) begin
        next_tick_cnt = 32'h0;
        if (steps >= mem.tout)
          next_tout_err = 1'b1;
        else
          next_steps = steps + 16'h1;
      end else begin
        next_tick_cnt = tick_cnt + 32'h1;
      end
    end
  end

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= 32'h0;
      steps <= 16'h0;
      dec_fault <= 1'b0;
      tout_err <= 1'b0;
    end else begin
      tick_cnt <= next_tick_cnt;
      steps <= next_steps;
      dec_fault <= next_dec_fault;
      tout_err <= next_tout_err;
    end
  end

  // ==========================================
  // packet sequencer
  spf_pkg::spf_state_t st, next_st;
  logic [4:0] pos, next_pos;
  logic [7:0] tx_data, next_tx_data;
  logic tx_valid, next_tx_valid, done;

  function automatic logic [7:0] pkt_byte(input logic [4:0] p, input spf_pkg::spf_fields_t f,
                                          input logic on, input logic tsd);
    logic [7:0] b;
    b = 8'h00;
    case (p)
      spf_pkg::POS_FIRST, 5'(spf_pkg::POS_FIRST + 5'h1): b = spf_pkg::START_BYTE;
      spf_pkg::POS_STATE: begin
        b = f.op_state;
        b[spf_pkg::BIT_ON] = on;
      end
      spf_pkg::POS_MODE: b[spf_pkg::BIT_TSD] = tsd;
      spf_pkg::POS_SRC: b = f.src;
      spf_pkg::POS_TOUT_HI: b = f.tout[15:8];
      spf_pkg::POS_TOUT_LO: b = f.tout[7:0];
      spf_pkg::POS_LSRC: b = f.lsrc;
      spf_pkg::POS_LIO: b[spf_pkg::BIT_APPROVED] = f.lio[spf_pkg::BIT_APPROVED];
      5'(spf_pkg::POS_LAST - 5'h1), spf_pkg::POS_LAST: b = spf_pkg::STOP_BYTE;
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  always_comb begin
    next_st = st;
    next_pos = pos;
    next_tx_data = tx_data;
    next_tx_valid = tx_valid;
    done = 1'b0;
    case (st)
      spf_pkg::SPF_IDLE: begin
        if (go) begin
          next_pos = spf_pkg::POS_FIRST;
          next_st = spf_pkg::SPF_SEND;
        end
      end
      spf_pkg::SPF_SEND: begin
        next_tx_data = pkt_byte(pos, mem, I_SYS_ON, I_TEC_SD);
        next_tx_valid = 1'b1;
        next_st = spf_pkg::SPF_WAIT;
      end
      spf_pkg::SPF_WAIT: begin
        if (I_TX_READY) begin
          next_tx_valid = 1'b0;
          if (pos == spf_pkg::POS_LAST) begin
            done = 1'b1;
            next_st = spf_pkg::SPF_IDLE;
          end else begin
            next_pos = pos + 5'h1;
            next_tx_data = pkt_byte(pos + 5'h1, mem, I_SYS_ON, I_TEC_SD);
            next_tx_valid = 1'b1;
          end
        end
      end
      default: next_st = spf_pkg::SPF_IDLE;
    endcase
  end

  assign busy = (st != spf_pkg::SPF_IDLE);
  assign ev = {done, next_tout_err & !tout_err, next_dec_fault & !dec_fault};

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      st <= spf_pkg::SPF_IDLE;
      pos <= 5'h0;
      tx_data <= 8'h00;
      tx_valid <= 1'b0;
      O_IRQ <= 1'b0;
    end else begin
      st <= next_st;
      pos <= next_pos;
      tx_data <= next_tx_data;
      tx_valid <= next_tx_valid;
      O_IRQ <= |(next_irq_stat & next_irq_mask);
    end
  end

  // ==========================================
  // outputs
  assign O_HRDATA = rdata;
  assign O_HREADYOUT = 1'b1;
  assign O_HRESP = 1'b0;
  assign O_TX_DATA = tx_data;
  assign O_TX_VALID = tx_valid;
  assign O_DEC_FAULT = dec_fault;
  assign O_TOUT_ERR = tout_err;
endmodule
`default_nettype wire

// File: rtl/spf_pkg.sv
// package for the status packet framer
package spf_pkg;
  // ahb register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATE = 8'h04;
  localparam logic [7:0] REG_SRC = 8'h08;
  localparam logic [7:0] REG_LSRC = 8'h0c;
  localparam logic [7:0] REG_TOUT = 8'h10;
  localparam logic [7:0] REG_IRQ_STAT = 8'h14;
  localparam logic [7:0] REG_IRQ_MASK = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1c;
  // packet layout
  localparam logic [7:0] START_BYTE = 8'h0a;
  localparam logic [7:0] STOP_BYTE = 8'h0b;
  localparam logic [4:0] POS_FIRST = 5'h01;
  localparam logic [4:0] POS_STATE = 5'h03;
  localparam logic [4:0] POS_MODE = 5'h04;
  localparam logic [4:0] POS_SRC = 5'h05;
  localparam logic [4:0] POS_TOUT_HI = 5'h15;
  localparam logic [4:0] POS_TOUT_LO = 5'h16;
  localparam logic [4:0] POS_LSRC = 5'h17;
  localparam logic [4:0] POS_LIO = 5'h18;
  localparam logic [4:0] POS_LAST = 5'h1a;
  // bit positions
  localparam int BIT_ON = 2;
  localparam int BIT_TSD = 4;
  localparam int BIT_APPROVED = 0;
  localparam int IRQ_DEC = 0;
  localparam int IRQ_TOUT = 1;
  localparam int IRQ_DONE = 2;
  // timeout tick: 100 ms at 25 MHz
  localparam int CLK_HZ = 25000000;
  localparam int TICK_MS = 100;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  typedef enum logic [1:0] {
    SPF_IDLE = 2'b00,
    SPF_SEND = 2'b01,
    SPF_WAIT = 2'b10
  } spf_state_t;
  typedef struct packed {
    logic [7:0] op_state;
    logic [7:0] src;
    logic [7:0] lsrc;
    logic [7:0] lio;
    logic [15:0] tout;
  } spf_fields_t;
endpackage
